// *** pkg/fsl_pkg.sv ***
// Package with constants and types for the fieldbus status LED encoder
package fsl_pkg;
    // Wishbone register word offsets (byte addresses)
    localparam logic [7:0] FSL_CTRL_ADDR = 8'h00;
    localparam logic [7:0] FSL_STAT_ADDR = 8'h04;
    localparam logic [7:0] FSL_SHORT_ADDR = 8'h08;
    localparam logic [7:0] FSL_LONG_ADDR = 8'h0C;
    localparam logic [7:0] FSL_ACTP_ADDR = 8'h10;
    // Control register bit positions
    localparam int FSL_CTRL_COMM = 0;
    localparam int FSL_CTRL_PH_LO = 1;
    localparam int FSL_CTRL_LOOP = 4;
    localparam int FSL_CTRL_APPERR = 5;
    localparam int FSL_CTRL_MST = 6;
    localparam int FSL_CTRL_WARN = 7;
    localparam int FSL_CTRL_COMERR = 8;
    localparam int FSL_CTRL_IDENT = 9;
    localparam int FSL_CTRL_IDCW = 10;
    // Clock and timing
    localparam int FSL_CLK_HZ = 100_000_000;
    localparam int FSL_MST_HOLD_S = 2;
    localparam int FSL_MST_HOLD_CYC = FSL_MST_HOLD_S * FSL_CLK_HZ;
    localparam logic [31:0] FSL_SHORT_RST = 32'h0098_9680;
    localparam logic [31:0] FSL_LONG_RST = 32'h02FA_F080;
    localparam logic [31:0] FSL_ACTP_RST = 32'h004C_4B40;
    localparam logic [31:0] FSL_CTRL_RST = 32'h0000_0000;
    // LED colour codes {red, green}; orange is both
    typedef enum logic [1:0] {
        FSL_OFF = 2'b00,
        FSL_GRN = 2'b01,
        FSL_RED = 2'b10,
        FSL_ORG = 2'b11
    } fsl_colour_type;
    // Bus status pattern selection
    typedef enum logic [3:0] {
        FSL_P_DARK, FSL_P_CP0, FSL_P_CPN, FSL_P_CP4, FSL_P_LOOP,
        FSL_P_APPERR, FSL_P_MST, FSL_P_COMERR, FSL_P_IDENT
    } fsl_pat_type;
endpackage : fsl_pkg

// *** src/fsl_port_led.sv ***
// Link/activity LED driver for one Ethernet port
`timescale 1ns/100ps
module fsl_port_led
    import fsl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic link_in,
    input wire logic act_in,
    input wire logic [31:0] act_period,
    output logic led
);
    // All state of this module
    typedef struct packed {
        logic [1:0] lnk_s;   // Link synchroniser
        logic [1:0] act_s;   // Activity synchroniser
        logic [31:0] cnt;    // Flash timer
        logic flashing;      // Activity seen in the previous window
        logic seen;          // Activity latched for the next window
        logic phase;         // Blink phase
        logic led;           // Registered output
    } fsl_port_type;
    fsl_port_type st_r, st_nxt;

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.lnk_s = {st_r.lnk_s[0], link_in};
        st_nxt.act_s = {st_r.act_s[0], act_in};
        // Activity pulses are brief; latch so a blink is visible
        if (st_r.act_s[1]) begin
            st_nxt.seen = 1'b1;
        end
        if (st_r.cnt >= act_period) begin
            st_nxt.cnt = 32'h0000_0000;
            st_nxt.phase = ~st_r.phase;
            if (st_r.phase) begin
                st_nxt.flashing = st_r.seen | st_r.act_s[1];
                st_nxt.seen = 1'b0;
            end
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h0000_0001;
        end
        if (!st_r.lnk_s[1]) begin
            st_nxt.led = 1'b0;             // No link, dark [R3] [R6]
        end else if (st_r.flashing) begin
            st_nxt.led = st_r.phase;       // Traffic blinks [R2] [R5]
        end else begin
            st_nxt.led = 1'b1;             // Link steady [R1] [R4]
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign led = st_r.led;
endmodule : fsl_port_led

// *** src/fsl_status_led.sv ***
// Status LED encoder: port link LEDs and bus status LED with Wishbone regs
`timescale 1ns/100ps
// Contract
// (R1) Port A link: steady green
// (R2) Port A traffic: flash green
// (R3) Port A no link: off
// (R4) Port B link: steady green
// (R5) Port B traffic: flash green
// (R6) Port B no link: off
// (R7) No communication: bus LED dark
// (R8) Phase zero: steady orange
// (R9) Phase one: one short green, long orange
// (R10) Phase two: two short green, long orange
// (R11) Phase three: three short green, long orange
// (R12) Phase four: steady green
// (R13) Fast-forward to loopback: flash green
// (R14) Application error: alternate red/orange
// (R15) Sync failure with warning: green/red, 2 s
// (R16) Communication error: steady red
// (R17) Identification request: flash orange
// (R18) Configurable flash timing, patterns complete; higher priorities cut short all patterns but CPN
// (R19) Priority: ident, errors, loopback, phase
module fsl_status_led
    import fsl_pkg::*;
#(
    parameter int MST_HOLD = FSL_MST_HOLD_CYC
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic PORT_A_LINK,
    input wire logic PORT_A_ACT,
    input wire logic PORT_B_LINK,
    input wire logic PORT_B_ACT,
    output logic PORT_A_LINK_ACTIVITY_LED,
    output logic PORT_B_LINK_ACTIVITY_LED,
    output logic BUS_STATUS_LED_GREEN,
    output logic BUS_STATUS_LED_RED
);
    // Refuse a hold time that the sync display logic cannot serve
    if (MST_HOLD < 1) begin : g_bad_hold
        $error("MST_HOLD must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////
    // Byte-lane write merge, used for every writable register
    function automatic logic [31:0] fsl_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : fsl_merge

    // All state of the top module
    typedef struct packed {
        logic [31:0] ctrl;       // Status inputs written by firmware
        logic [31:0] short_len;  // Short flash length in cycles
        logic [31:0] long_len;   // Long flash length in cycles
        logic [31:0] act_per;    // Activity blink half period
        logic ack;               // Wishbone acknowledge
        logic [31:0] rdat;       // Read data
        logic loop_d;            // Loopback, previous value
        logic loop_ev;           // Loopback event indication active
        logic [31:0] mst_cnt;    // Sync failure minimum hold timer
        logic [3:0] pat;         // Pattern being shown
        logic [1:0] pat_ph;      // Phase count frozen at pattern start
        logic [2:0] step;        // Step within pattern
        logic [31:0] tcnt;       // Step timer
        logic [1:0] led;         // {red, green}
    } fsl_top_type;
    fsl_top_type st_r, st_nxt;

    logic [2:0] phase;      // Communication phase field
    logic mst_act;          // Sync failure display active
    fsl_pat_type want;      // Pattern chosen by priority
    logic [31:0] step_len;  // Length of the current step
    logic [2:0] nsteps;     // Steps in the current pattern
    fsl_colour_type col;    // Colour for the current step
    logic req;              // Bus request this cycle

    assign phase = st_r.ctrl[FSL_CTRL_PH_LO +: 3];
    assign mst_act = (st_r.ctrl[FSL_CTRL_MST] & st_r.ctrl[FSL_CTRL_WARN])
        | (st_r.mst_cnt != 32'h0000_0000);
    assign req = WB_CYC_I & WB_STB_I & ~st_r.ack;

    ////////////////////////////////////////////////////////////////////
    // Priority selection of the bus status pattern
    always_comb begin
        if (st_r.ctrl[FSL_CTRL_IDENT] | st_r.ctrl[FSL_CTRL_IDCW]) begin
            want = FSL_P_IDENT;           // Identification first [R17] [R19]
        end else if (st_r.ctrl[FSL_CTRL_COMERR]) begin
            want = FSL_P_COMERR;          // [R16] [R19]
        end else if (mst_act) begin
            want = FSL_P_MST;             // [R15] [R19]
        end else if (st_r.ctrl[FSL_CTRL_APPERR]) begin
            want = FSL_P_APPERR;          // [R14] [R19]
        end else if (st_r.loop_ev) begin
            want = FSL_P_LOOP;            // [R13] [R19]
        end else if (!st_r.ctrl[FSL_CTRL_COMM]) begin
            want = FSL_P_DARK;            // [R7]
        end else if (phase == 3'd0) begin
            want = FSL_P_CP0;
        end else if (phase >= 3'd4) begin
            want = FSL_P_CP4;
        end else begin
            want = FSL_P_CPN;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Step table: colour, length and count of steps per pattern
    always_comb begin
        step_len = st_r.short_len;
        nsteps = 3'd2;
        col = FSL_OFF;
        case (fsl_pat_type'(st_r.pat))
            FSL_P_CP0: begin
                col = FSL_ORG;                                   // [R8]
            end
            FSL_P_CP4: begin
                col = FSL_GRN;                                   // [R12]
            end
            FSL_P_COMERR: begin
                col = FSL_RED;                                   // [R16]
            end
            FSL_P_CPN: begin
                // Short green/off pairs then one long orange [R9] [R10] [R11]
                // Frozen count keeps a running pattern whole [R18]
                nsteps = {st_r.pat_ph, 1'b0} + 3'd1;
                if (st_r.step == nsteps - 3'd1) begin
                    col = FSL_ORG;
                    step_len = st_r.long_len;
                end else begin
                    col = st_r.step[0] ? FSL_OFF : FSL_GRN;
                end
            end
            FSL_P_LOOP: begin
                col = st_r.step[0] ? FSL_OFF : FSL_GRN;          // [R13]
            end
            FSL_P_APPERR: begin
                col = st_r.step[0] ? FSL_ORG : FSL_RED;          // [R14]
            end
            FSL_P_MST: begin
                col = st_r.step[0] ? FSL_RED : FSL_GRN;          // [R15]
            end
            FSL_P_IDENT: begin
                col = st_r.step[0] ? FSL_OFF : FSL_ORG;          // [R17]
            end
            default: begin
                col = FSL_OFF;                                   // [R7]
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next state: bus slave, event capture and pattern sequencer
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req;
        // Write port; writes land on the acknowledge edge
        if (req && WB_WE_I) begin
            if (WB_ADR_I == FSL_CTRL_ADDR) begin
                st_nxt.ctrl = fsl_merge(st_r.ctrl, WB_DAT_I, WB_SEL_I);
            end else if (WB_ADR_I == FSL_SHORT_ADDR) begin
                st_nxt.short_len = fsl_merge(st_r.short_len, WB_DAT_I,
                    WB_SEL_I);
            end else if (WB_ADR_I == FSL_LONG_ADDR) begin
                st_nxt.long_len = fsl_merge(st_r.long_len, WB_DAT_I,
                    WB_SEL_I);
            end else if (WB_ADR_I == FSL_ACTP_ADDR) begin
                st_nxt.act_per = fsl_merge(st_r.act_per, WB_DAT_I,
                    WB_SEL_I);
            end
        end
        // Read port; unmapped addresses read zero
        if (WB_ADR_I == FSL_CTRL_ADDR) begin
            st_nxt.rdat = st_r.ctrl;
        end else if (WB_ADR_I == FSL_STAT_ADDR) begin
            st_nxt.rdat = {16'h0000, st_r.pat, 1'b0, st_r.step,
                4'h0, mst_act, st_r.loop_ev, st_r.led};
        end else if (WB_ADR_I == FSL_SHORT_ADDR) begin
            st_nxt.rdat = st_r.short_len;
        end else if (WB_ADR_I == FSL_LONG_ADDR) begin
            st_nxt.rdat = st_r.long_len;
        end else if (WB_ADR_I == FSL_ACTP_ADDR) begin
            st_nxt.rdat = st_r.act_per;
        end else begin
            st_nxt.rdat = 32'h0000_0000;
        end
        // Rising loopback edge starts a flash; new edge wins over end [R13]
        st_nxt.loop_d = st_r.ctrl[FSL_CTRL_LOOP];
        // Event is consumed once its flash shows, so it flashes once
        if (st_r.pat == 4'(FSL_P_LOOP)) begin
            st_nxt.loop_ev = 1'b0;
        end
        if (st_r.ctrl[FSL_CTRL_LOOP] && !st_r.loop_d) begin
            st_nxt.loop_ev = 1'b1;
        end
        // Sync failure display lasts at least the hold time [R15]
        if (st_r.ctrl[FSL_CTRL_MST] && st_r.ctrl[FSL_CTRL_WARN]) begin
            st_nxt.mst_cnt = 32'(MST_HOLD);
        end else if (st_r.mst_cnt != 32'h0000_0000) begin
            st_nxt.mst_cnt = st_r.mst_cnt - 32'h0000_0001;
        end
        // Sequencer: lower priorities, and any change during CPN, switch only at pattern end [R18]
        st_nxt.led = col;
        if (st_r.tcnt >= step_len) begin
            st_nxt.tcnt = 32'h0000_0000;
            if (st_r.step >= nsteps - 3'd1) begin
                st_nxt.step = 3'd0;
                st_nxt.pat = 4'(want);     // [R18] [R19]
                st_nxt.pat_ph = phase[1:0];
            end else begin
                st_nxt.step = st_r.step + 3'd1;
            end
        end else begin
            st_nxt.tcnt = st_r.tcnt + 32'h0000_0001;
        end
        // Higher priorities take over at once, except from a running CPN pattern
        if (4'(want) > st_r.pat && st_r.pat != 4'(FSL_P_CPN)) begin
            st_nxt.pat = 4'(want);         // [R19]
            st_nxt.pat_ph = phase[1:0];
            st_nxt.step = 3'd0;
            st_nxt.tcnt = 32'h0000_0000;
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_r <= '0;
            st_r.ctrl <= FSL_CTRL_RST;
            st_r.short_len <= FSL_SHORT_RST;
            st_r.long_len <= FSL_LONG_RST;
            st_r.act_per <= FSL_ACTP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-port link/activity drivers
    fsl_port_led u_port_a (
        .clk(CLK),
        .rst(SYS_RST),
        .link_in(PORT_A_LINK),
        .act_in(PORT_A_ACT),
        .act_period(st_r.act_per),
        .led(PORT_A_LINK_ACTIVITY_LED)
    );
    fsl_port_led u_port_b (
        .clk(CLK),
        .rst(SYS_RST),
        .link_in(PORT_B_LINK),
        .act_in(PORT_B_ACT),
        .act_period(st_r.act_per),
        .led(PORT_B_LINK_ACTIVITY_LED)
    );

    assign WB_DAT_O = st_r.rdat;
    assign WB_ACK_O = st_r.ack;
    assign BUS_STATUS_LED_GREEN = st_r.led[0];
    assign BUS_STATUS_LED_RED = st_r.led[1];
endmodule : fsl_status_led

// *** dv/fsl_ring_model.sv ***
// Behavioural ring master: link and traffic for both ports
`timescale 1ns/100ps
module fsl_ring_model (
    input wire logic clk,
    input wire logic [1:0] link_en,
    input wire logic [1:0] traffic_en,
    output logic [1:0] link = 2'b00,
    output logic [1:0] act = 2'b00
);
    // Frame tick; traffic appears as a pulse once per tick
    logic [2:0] tick_r = 3'h0;
    ////////////////////////////////////////////////////////////////
    // Traffic is only seen on a port whose link is up
    always_ff @(posedge clk) begin
        tick_r <= tick_r + 3'h1;
        link <= link_en;
        act <= traffic_en & link_en & {2{tick_r == 3'h0}};
    end
endmodule : fsl_ring_model

// *** dv/fsl_status_led_properties.sv ***
// Concurrent properties for the status LED encoder ports
`timescale 1ns/100ps
module fsl_sva_checker
    import fsl_pkg::*;
#(
    parameter int MST_HOLD = FSL_MST_HOLD_CYC
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic PORT_A_LINK,
    input wire logic PORT_A_ACT,
    input wire logic PORT_B_LINK,
    input wire logic PORT_B_ACT,
    input wire logic PORT_A_LINK_ACTIVITY_LED,
    input wire logic PORT_B_LINK_ACTIVITY_LED,
    input wire logic BUS_STATUS_LED_GREEN,
    input wire logic BUS_STATUS_LED_RED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Shadow of the control word, taken at acked writes
    logic [10:0] ctl_r;
    // Quiet cycles since the last control write; saturates at 255, enough for
    // patterns and the sync hold to settle with the bench's shortened timing
    logic [7:0] quiet_r;
    logic wr_ctl;
    assign wr_ctl = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O
        && (WB_ADR_I == FSL_CTRL_ADDR);
    ////////////////////////////////////////////////////////////////
    // Shadow and quiet counter
    always_ff @(posedge CLK) begin
        if (SYS_RST || wr_ctl) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hFF) begin
            quiet_r <= quiet_r + 8'h01;
        end
        if (SYS_RST) begin
            ctl_r <= 11'h000;
        end else if (wr_ctl) begin
            if (WB_SEL_I[0]) ctl_r[7:0] <= WB_DAT_I[7:0];
            if (WB_SEL_I[1]) ctl_r[10:8] <= WB_DAT_I[10:8];
        end
    end
    logic calm;
    assign calm = (quiet_r == 8'hFF);
    ////////////////////////////////////////////////////////////////
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O) else $error("request not acked next cycle");
    ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
        else $error("ack without request");
    reset_dark_a: assert property (disable iff (1'b0) SYS_RST [*2] |=>
        !BUS_STATUS_LED_GREEN && !BUS_STATUS_LED_RED && !WB_ACK_O)
        else $error("outputs active during reset");
    port_a_off_a: assert property (!PORT_A_LINK [*4] |=>
        !PORT_A_LINK_ACTIVITY_LED) else $error("port A lit w/o link");
    port_b_off_a: assert property (!PORT_B_LINK [*4] |=>
        !PORT_B_LINK_ACTIVITY_LED) else $error("port B lit w/o link");
    bus_dark_a: assert property (calm && ctl_r == 11'h000 |->
        !BUS_STATUS_LED_GREEN && !BUS_STATUS_LED_RED)
        else $error("bus LED lit with no comms");
    phase_zero_a: assert property (calm && ctl_r == 11'h001 |->
        BUS_STATUS_LED_GREEN && BUS_STATUS_LED_RED)
        else $error("phase zero not orange");
    phase_four_a: assert property (calm && ctl_r == 11'h009 |->
        BUS_STATUS_LED_GREEN && !BUS_STATUS_LED_RED)
        else $error("phase four not green");
    comm_error_a: assert property (calm && ctl_r == 11'h101 |->
        !BUS_STATUS_LED_GREEN && BUS_STATUS_LED_RED)
        else $error("comm error not red");
    cover property (WB_ACK_O && WB_WE_I);
    cover property (calm && ctl_r == 11'h009);
    cover property (PORT_A_LINK_ACTIVITY_LED && PORT_A_ACT);
endmodule : fsl_sva_checker

bind fsl_status_led fsl_sva_checker #(.MST_HOLD(MST_HOLD)) u_chk (.*);

// *** dv/fsl_status_led_tb_top.sv ***
// Self-checking bench for the status LED encoder
`timescale 1ns/100ps
module fsl_status_led_tb_top
    import fsl_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic we = 1'b0;
    logic cyc = 1'b0; // Drives cyc and stb together
    logic [3:0] sel = 4'hF; // Byte lanes; all but one test use all four
    logic [31:0] rdat;
    logic ack;
    logic [1:0] link_en = 2'b00;
    logic [1:0] traffic_en = 2'b00;
    logic [1:0] link;
    logic [1:0] act;
    logic [1:0] pled;
    logic grn;
    logic red;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [3:0] m;
    logic [3:0] k;
    ////////////////////////////////////////////////////////////////
    // Short hold keeps the sync display test brief
    fsl_status_led #(.MST_HOLD(50)) dut (.CLK(clk), .SYS_RST(sys_rst),
        .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we),
        .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PORT_A_LINK(link[0]), .PORT_A_ACT(act[0]),
        .PORT_B_LINK(link[1]), .PORT_B_ACT(act[1]),
        .PORT_A_LINK_ACTIVITY_LED(pled[0]),
        .PORT_B_LINK_ACTIVITY_LED(pled[1]),
        .BUS_STATUS_LED_GREEN(grn), .BUS_STATUS_LED_RED(red));
    fsl_ring_model ring (.clk(clk), .link_en(link_en),
        .traffic_en(traffic_en), .link(link), .act(act));
    initial forever #5 clk = ~clk;
    // Hang guard: far above the few thousand cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One classic cycle; hold everything until ack is sampled
    task automatic wb(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0000_0000, q);
        check(q, exp);
    endtask : rd
    // Bus colours over n cycles as a mask {off, orange, red, green}
    task automatic watch(input int n, output logic [3:0] mk);
        mk = 4'h0;
        repeat (n) begin
            @(negedge clk);
            mk[2'({red, grn} - 2'b01)] = 1'b1;
        end
    endtask : watch
    // Write control word, let patterns settle, then observe
    task automatic bus(input logic [10:0] c, input logic [3:0] exp);
        wr(FSL_CTRL_ADDR, {21'h0, c});
        repeat (150) @(negedge clk);
        watch(150, m);
        check(m, exp);
    endtask : bus
    // Port LED states seen after settling, as a mask {on, off}
    task automatic pcheck(input int p, input logic [1:0] exp);
        logic [1:0] pm;
        pm = 2'b00;
        repeat (20) @(negedge clk);
        repeat (60) begin
            @(negedge clk);
            pm[pled[p]] = 1'b1;
        end
        check(pm, exp);
    endtask : pcheck
    // Short green flashes between two long orange steps
    task automatic count_green(output logic [3:0] kk);
        logic prev;
        kk = 4'h0;
        prev = 1'b0;
        while (!(grn && red)) @(negedge clk);
        while (grn && red) @(negedge clk);
        while (!(grn && red)) begin
            if (grn && !prev) kk++;
            prev = grn;
            @(negedge clk);
        end
    endtask : count_green
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(FSL_CTRL_ADDR, FSL_CTRL_RST);
        rd(FSL_STAT_ADDR, 32'h0000_0000);
        rd(FSL_SHORT_ADDR, FSL_SHORT_RST);
        rd(FSL_LONG_ADDR, FSL_LONG_RST);
        rd(FSL_ACTP_ADDR, FSL_ACTP_RST);
        rd(8'h20, 32'h0000_0000);
        // Shrink flash and blink timing so patterns fit the run
        for (int a = 8; a <= 16; a += 4) begin
            wr(8'(a), 32'h0000_0004);
            rd(8'(a), 32'h0000_0004);
        end
        // Only the low byte lane may land
        sel <= 4'h1;
        wr(FSL_ACTP_ADDR, 32'hFFFF_FF05);
        sel <= 4'hF;
        rd(FSL_ACTP_ADDR, 32'h0000_0005);
        for (int p = 0; p < 2; p++) begin
            link_en[p] <= 1'b1;
            pcheck(p, 2'b10);
            traffic_en[p] <= 1'b1;
            pcheck(p, 2'b11);
            link_en[p] <= 1'b0;
            traffic_en[p] <= 1'b0;
            pcheck(p, 2'b01);
        end
        bus(11'h000, 4'h8);
        bus(11'h001, 4'h4);
        for (int n = 1; n <= 3; n++) begin
            wr(FSL_CTRL_ADDR, 32'h0000_0001 | 32'(n << 1));
            count_green(k);
            count_green(k);
            check(k, 4'(n));
        end
        bus(11'h009, 4'h1);
        wr(FSL_CTRL_ADDR, 32'h0000_0019);
        watch(30, m);
        check(m, 4'h9);
        bus(11'h101, 4'h2);
        bus(11'h021, 4'h6);
        bus(11'h0C1, 4'h3);
        wr(FSL_CTRL_ADDR, 32'h0000_0009);
        watch(30, m);
        check(m[1], 1'b1);
        bus(11'h209, 4'hC);
        bus(11'h401, 4'hC);
        bus(11'h309, 4'hC);
        bus(11'h121, 4'h2);
        tally_and_finish();
    end
endmodule : fsl_status_led_tb_top
